/* chan_reconfig.sv */
// transceiver channel reconfiguration controller with apb register access
//
// Our own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module chan_reconfig
	import reconfig_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire apb_req_s apb_req,
	output var apb_rsp_s apb_rsp,
	input wire logic cal_done,
	output var logic busy,
	output var chan_cfg_s [NCH-1:0] chan_cfg,
	output var logic [NPLL-1:0][RATE_W-1:0] pll_rate
);
	typedef struct packed {
		logic [1:0] cal_sync;
		state_e st;
		apb_rsp_s rsp;
		cmd_s pend;
		chan_cfg_s [NCH-1:0] cfg;
		logic [NPLL-1:0][RATE_W-1:0] rate;
		logic err;
		logic ovr;
		logic busy;
	} regs_s;

	regs_s r_ff;
	regs_s nxt_r;
	logic tmr_start;
	logic tmr_done;
	logic acc_first;
	logic wr_commit;
	logic cmd_wr;
	cmd_s wcmd;

	function automatic logic chan_hit(logic [7:0] a);
		return a >= OFF_CHAN && a <= OFF_CHAN_LAST && a[1:0] == 2'h0;
	endfunction : chan_hit

	function automatic logic [CH_W-1:0] chan_idx(logic [7:0] a);
		logic [7:0] d;
		d = a - OFF_CHAN;
		return d[CH_W+1:2];
	endfunction : chan_idx

	function automatic logic mapped(logic [7:0] a);
		return a == OFF_STATUS || a == OFF_CMD || a == OFF_PLL || chan_hit(a);
	endfunction : mapped

	function automatic logic cmd_legal(chan_cfg_s c, cmd_s k);
		logic ok;
		ok = 1'b1;
		case (k.op)
			OP_DIV: begin
				ok = k.arg[7:2] == 6'h00;
			end
			OP_PLLSEL: begin
				ok = k.arg[7:1] == 7'h00;
			end
			OP_DIR: begin
				ok = k.arg[7:2] == 6'h00 && k.arg[1:0] != DIR_BAD
					&& !(c.dir == DIR_TX && k.arg[1:0] == DIR_RX)
					&& !(c.dir == DIR_RX && k.arg[1:0] == DIR_TX);
			end
			default: begin
				ok = 1'b1;
			end
		endcase
		return ok;
	endfunction : cmd_legal

	function automatic chan_cfg_s apply_chan(chan_cfg_s c, cmd_s k);
		chan_cfg_s o;
		o = c;
		case (k.op)
			OP_CDR: begin
				o.cdr_rate = k.arg[RATE_W-1:0];
			end
			OP_PCS: begin
				o.pcs_en = k.arg;
			end
			OP_CODER: begin
				o.pcs_en[PCS_CODER_BIT] = k.arg[0];
			end
			OP_PLLSEL: begin
				o.pll_sel = k.arg[0];
			end
			OP_DIV: begin
				o.div_code = k.arg[1:0];
			end
			OP_WIDTH: begin
				o.pcs_width = k.arg[2:0];
				o.pma_width = k.arg[5:3];
			end
			OP_DIR: begin
				o.dir = k.arg[1:0];
			end
			default: begin
				o = c;
			end
		endcase
		return o;
	endfunction : apply_chan

	function automatic logic [31:0] rd_mux(regs_s s, logic [7:0] a);
		logic [31:0] d;
		d = 32'h0000_0000;
		if (a == OFF_STATUS) begin
			d[ST_BUSY_BIT] = s.busy;
			d[ST_READY_BIT] = s.st != ST_CAL;
			d[ST_ERR_BIT] = s.err;
			d[ST_OVR_BIT] = s.ovr;
		end else if (a == OFF_CMD) begin
			d[CMD_CH_LSB +: CH_W] = s.pend.ch;
			d[CMD_OP_LSB +: 3] = s.pend.op;
			d[CMD_ARG_LSB +: 8] = s.pend.arg;
		end else if (a == OFF_PLL) begin
			for (int i = 0; i < NPLL; i++) begin
				d[i*PLL_FIELD_W +: RATE_W] = s.rate[i];
			end
		end else if (chan_hit(a)) begin
			d[$bits(chan_cfg_s)-1:0] = s.cfg[chan_idx(a)];
		end
		return d;
	endfunction : rd_mux

	assign wcmd = '{ch: apb_req.pwdata[CMD_CH_LSB +: CH_W],
		op: apb_req.pwdata[CMD_OP_LSB +: 3],
		arg: apb_req.pwdata[CMD_ARG_LSB +: 8]};
	// one wait state: pready rises on the second access cycle
	assign acc_first = apb_req.psel && apb_req.penable && !r_ff.rsp.pready;
	assign wr_commit = apb_req.psel && apb_req.penable && r_ff.rsp.pready
		&& apb_req.pwrite;
	assign cmd_wr = wr_commit && apb_req.paddr == OFF_CMD;

	always_comb begin
		nxt_r = r_ff;
		tmr_start = 1'b0;
		nxt_r.cal_sync = {r_ff.cal_sync[0], cal_done};
		nxt_r.rsp.pready = acc_first;
		if (acc_first) begin
			nxt_r.rsp.prdata = rd_mux(r_ff, apb_req.paddr);
			nxt_r.rsp.pslverr = !mapped(apb_req.paddr);
		end
		// error bits clear first so a same-cycle new error wins
		if (wr_commit && apb_req.paddr == OFF_STATUS) begin
			if (apb_req.pwdata[ST_ERR_BIT]) begin
				nxt_r.err = 1'b0;
			end
			if (apb_req.pwdata[ST_OVR_BIT]) begin
				nxt_r.ovr = 1'b0;
			end
		end
		case (r_ff.st)
			ST_CAL: begin
				if (r_ff.cal_sync[1]) begin
					nxt_r.st = ST_IDLE;
				end
			end
			ST_IDLE: begin
				if (cmd_wr) begin
					if (cmd_legal(r_ff.cfg[wcmd.ch], wcmd)) begin
						nxt_r.pend = wcmd;
						nxt_r.st = ST_APPLY;
						tmr_start = 1'b1;
					end else begin
						nxt_r.err = 1'b1;
					end
				end
			end
			ST_APPLY: begin
				if (tmr_done) begin
					// OP_PLLRATE rewrites one pll rate; any other op rewrites only the addressed channel
					if (r_ff.pend.op == OP_PLLRATE) begin
						nxt_r.rate[r_ff.pend.arg[PLLRATE_IDX_BIT]] =
							r_ff.pend.arg[RATE_W-1:0];
					end else begin
						nxt_r.cfg[r_ff.pend.ch] =
							apply_chan(r_ff.cfg[r_ff.pend.ch], r_ff.pend);
					end
					nxt_r.st = ST_IDLE;
				end
			end
			default: begin
				nxt_r.st = ST_CAL;
			end
		endcase
		// a command during calibration or a running change is refused
		if (cmd_wr && r_ff.st != ST_IDLE) begin
			nxt_r.ovr = 1'b1;
			nxt_r.err = 1'b1;
		end
		for (int i = 0; i < NCH; i++) begin
			nxt_r.cfg[i].tx_rate = nxt_r.rate[nxt_r.cfg[i].pll_sel];
		end
		nxt_r.busy = nxt_r.st != ST_IDLE;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_ff <= '{cal_sync: 2'h0, st: ST_CAL, rsp: '0, pend: '0,
				cfg: {NCH{RST_CHAN}}, rate: '0, err: 1'b0, ovr: 1'b0,
				busy: 1'b1};
		end else begin
			r_ff <= nxt_r;
		end
	end

	settle_timer u_settle (
		.pclk(pclk),
		.presetn(presetn),
		.start(tmr_start),
		.done(tmr_done)
	);

	assign apb_rsp = r_ff.rsp;
	assign busy = r_ff.busy;
	assign chan_cfg = r_ff.cfg;
	assign pll_rate = r_ff.rate;

	a_apb_wait_state: assert property (@(posedge pclk) disable iff (!presetn)
		acc_first |=> apb_rsp.pready ##1 !apb_rsp.pready)
		else $error("apb ready not one wait state");

	a_accept_busy: assert property (@(posedge pclk) disable iff (!presetn)
		cmd_wr && r_ff.st == ST_IDLE && cmd_legal(r_ff.cfg[wcmd.ch], wcmd)
		|=> busy [*8])
		else $error("busy not held after accepted command");

	a_refuse_busy: assert property (@(posedge pclk) disable iff (!presetn)
		cmd_wr && r_ff.st == ST_APPLY |=> r_ff.ovr && $stable(r_ff.pend))
		else $error("command during busy not refused");

	a_cal_hold: assert property (@(posedge pclk) disable iff (!presetn)
		r_ff.st == ST_CAL |-> busy ##1 $stable(chan_cfg))
		else $error("configuration changed before calibration");

	a_div_range: assert property (@(posedge pclk) disable iff (!presetn)
		cmd_wr && r_ff.st == ST_IDLE && wcmd.op == OP_DIV
		&& wcmd.arg[7:2] != 6'h00 |=> r_ff.err && !busy)
		else $error("bad divider code not refused");

	a_cdr_commit: assert property (@(posedge pclk) disable iff (!presetn)
		r_ff.st == ST_APPLY && tmr_done && r_ff.pend.op == OP_CDR
		|=> chan_cfg[$past(r_ff.pend.ch)].cdr_rate
			== $past(r_ff.pend.arg[RATE_W-1:0]) && !busy)
		else $error("cdr rate not committed");

	for (genvar g = 0; g < NCH; g++) begin : g_chk
		a_dir_block: assert property (@(posedge pclk) disable iff (!presetn)
			!($past(chan_cfg[g].dir) == DIR_TX && chan_cfg[g].dir == DIR_RX)
			&& !($past(chan_cfg[g].dir) == DIR_RX && chan_cfg[g].dir == DIR_TX))
			else $error("forbidden direction change");
		a_other_chan: assert property (@(posedge pclk) disable iff (!presetn)
			r_ff.st == ST_APPLY && tmr_done && r_ff.pend.ch != g
			|=> $stable(chan_cfg[g].pcs_en) && $stable(chan_cfg[g].dir)
				&& $stable(chan_cfg[g].div_code))
			else $error("unaddressed channel changed");
		a_pll_follow: assert property (@(posedge pclk) disable iff (!presetn)
			chan_cfg[g].tx_rate == pll_rate[chan_cfg[g].pll_sel])
			else $error("channel rate not following its pll");
	end
endmodule : chan_reconfig
`default_nettype wire

/* reconfig_pkg.sv */
// constants, register map and types of the channel reconfiguration block
package reconfig_pkg;
	localparam int NCH = 4;
	localparam int NPLL = 2;
	localparam int CH_W = 2;
	localparam int RATE_W = 4;

	// register byte offsets
	localparam logic [7:0] OFF_STATUS = 8'h00;
	localparam logic [7:0] OFF_CMD = 8'h04;
	localparam logic [7:0] OFF_PLL = 8'h08;
	localparam logic [7:0] OFF_CHAN = 8'h10;
	localparam logic [7:0] OFF_CHAN_LAST = 8'h1c;

	// status bits
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_READY_BIT = 1;
	localparam int ST_ERR_BIT = 2;
	localparam int ST_OVR_BIT = 3;

	// command word fields
	localparam int CMD_CH_LSB = 0;
	localparam int CMD_OP_LSB = 4;
	localparam int CMD_ARG_LSB = 8;
	localparam int PLL_FIELD_W = 8;

	// command opcodes
	localparam logic [2:0] OP_CDR = 3'h0;
	localparam logic [2:0] OP_PCS = 3'h1;
	localparam logic [2:0] OP_CODER = 3'h2;
	localparam logic [2:0] OP_PLLSEL = 3'h3;
	localparam logic [2:0] OP_DIV = 3'h4;
	localparam logic [2:0] OP_WIDTH = 3'h5;
	localparam logic [2:0] OP_DIR = 3'h6;
	localparam logic [2:0] OP_PLLRATE = 3'h7;

	// pcs enable bit that gates the 8b/10b coder
	localparam int PCS_CODER_BIT = 0;
	localparam int PLLRATE_IDX_BIT = 7;

	// channel direction codes
	localparam logic [1:0] DIR_DUPLEX = 2'h0;
	localparam logic [1:0] DIR_TX = 2'h1;
	localparam logic [1:0] DIR_RX = 2'h2;
	localparam logic [1:0] DIR_BAD = 2'h3;

	// divider codes 0..3 select divide by 1, 2, 4, 8
	localparam logic [1:0] DIV_BY1 = 2'h0;

	// settle time after each change
	localparam int CLK_PERIOD_PS = 5000;
	localparam int SETTLE_NS = 100;
	localparam int SETTLE_CYC = (SETTLE_NS * 1000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;

	typedef enum logic [1:0] {ST_CAL, ST_IDLE, ST_APPLY} state_e;

	typedef struct packed {
		logic [1:0] dir;
		logic [RATE_W-1:0] cdr_rate;
		logic [7:0] pcs_en;
		logic pll_sel;
		logic [1:0] div_code;
		logic [2:0] pcs_width;
		logic [2:0] pma_width;
		logic [RATE_W-1:0] tx_rate;
	} chan_cfg_s;

	typedef struct packed {
		logic [CH_W-1:0] ch;
		logic [2:0] op;
		logic [7:0] arg;
	} cmd_s;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} apb_req_s;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} apb_rsp_s;

	localparam logic [RATE_W-1:0] RST_RATE = 4'h0;
	localparam chan_cfg_s RST_CHAN = '{dir: DIR_DUPLEX, cdr_rate: RST_RATE,
		pcs_en: 8'hff, pll_sel: 1'b0, div_code: DIV_BY1,
		pcs_width: 3'h0, pma_width: 3'h0, tx_rate: RST_RATE};
endpackage : reconfig_pkg

/* settle_timer.sv */
// settle timer that paces each committed reconfiguration
`timescale 1ns/1ps
`default_nettype none
module settle_timer
	import reconfig_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic start,
	output var logic done
);
	localparam int SC1 = SETTLE_CYC + 1;

	typedef struct packed {
		logic [7:0] cnt;
		logic run;
		logic done;
	} tmr_s;

	tmr_s r_ff;
	tmr_s nxt_r;

	always_comb begin
		nxt_r = r_ff;
		nxt_r.done = 1'b0;
		// a start while running is ignored; the caller waits on done
		if (start && !r_ff.run) begin
			nxt_r.run = 1'b1;
			nxt_r.cnt = 8'(SETTLE_CYC - 1);
		end else if (r_ff.run) begin
			if (r_ff.cnt == 8'h00) begin
				nxt_r.run = 1'b0;
				nxt_r.done = 1'b1;
			end else begin
				nxt_r.cnt = r_ff.cnt - 8'h01;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_ff <= '0;
		end else begin
			r_ff <= nxt_r;
		end
	end

	assign done = r_ff.done;

	a_settle_time: assert property (@(posedge pclk) disable iff (!presetn)
		start && !r_ff.run |-> ##SC1 done)
		else $error("settle done not at expected cycle");
endmodule : settle_timer
`default_nettype wire

/* fabric_requester.sv */
// fabric-side apb requester model for the reconfiguration block
`timescale 1ns/1ps
`default_nettype none
module fabric_requester
	import reconfig_pkg::*;
(
	input wire logic pclk,
	input wire apb_rsp_s rsp,
	output var apb_req_s req
);
	initial req = '0;

	// one transfer, held until pready is sampled; n counts edges used
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e, output int n);
		@(posedge pclk);
		req <= '{1'b1, 1'b0, w, a, d};
		@(posedge pclk);
		req.penable <= 1'b1;
		n = 2;
		// pready is looked at mid-cycle: at the launching edge it races
		@(negedge pclk);
		while (rsp.pready !== 1'b1) begin
			@(negedge pclk);
			n++;
		end
		// the edge that samples pready high commits the transfer
		@(posedge pclk);
		n++;
		q = rsp.prdata;
		e = rsp.pslverr;
		// released lines show junk, so stale values cannot pass
		req <= '{1'b0, 1'b0, ~w, ~a, ~d};
	endtask : xfer

	// polls status; the next command waits for busy low
	task wait_idle(output logic ok);
		logic [31:0] q;
		logic e;
		int n, k;
		k = 0;
		do begin
			xfer(1'b0, OFF_STATUS, 32'h0, q, e, n);
			k++;
		end while (q[ST_BUSY_BIT] !== 1'b0 && k < 40);
		ok = (q[ST_BUSY_BIT] === 1'b0);
	endtask : wait_idle
endmodule : fabric_requester
`default_nettype wire

/* transceiver_channel_reconfig_bench.sv */
// self-checking bench for the channel reconfiguration controller
`timescale 1ns/1ps
`default_nettype none
module transceiver_channel_reconfig_bench
	import reconfig_pkg::*;
;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic cal_done = 1'b0;
	apb_req_s apb_req;
	apb_rsp_s apb_rsp;
	logic busy;
	chan_cfg_s [NCH-1:0] cfg, exp;
	logic [NPLL-1:0][RATE_W-1:0] pll, exp_pll;
	logic [31:0] q;
	logic e, ok;
	int n;
	int bad_count = 0;
	int num_checks = 0;

	always #2.5 pclk = ~pclk;

	chan_reconfig dut_u (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
		.apb_rsp(apb_rsp), .cal_done(cal_done), .busy(busy),
		.chan_cfg(cfg), .pll_rate(pll));
	fabric_requester u_host (.pclk(pclk), .rsp(apb_rsp), .req(apb_req));

	task chk(input string nm, input logic [127:0] x, input logic [127:0] y);
		num_checks++;
		if (x !== y) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", nm, x, y);
		end
	endtask : chk

	task conclude();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : conclude

	function automatic void retx();
		for (int c = 0; c < NCH; c++)
			exp[c].tx_rate = exp_pll[exp[c].pll_sel];
	endfunction : retx

	// legal commands settle a fixed span; ov adds a write while busy
	task cmd(input logic [1:0] ch, input logic [2:0] op,
		input logic [7:0] arg, input logic good, input logic ov);
		chan_cfg_s [NCH-1:0] was;
		was = exp;
		if (good) begin
			case (op)
			OP_CDR: exp[ch].cdr_rate = arg[3:0];
			OP_PCS: exp[ch].pcs_en = arg;
			OP_CODER: exp[ch].pcs_en[PCS_CODER_BIT] = arg[0];
			OP_PLLSEL: exp[ch].pll_sel = arg[0];
			OP_DIV: exp[ch].div_code = arg[1:0];
			OP_WIDTH: {exp[ch].pma_width, exp[ch].pcs_width} = arg[5:0];
			OP_DIR: exp[ch].dir = arg[1:0];
			default: exp_pll[arg[PLLRATE_IDX_BIT]] = arg[3:0];
			endcase
			retx();
		end
		u_host.xfer(1'b1, OFF_CMD, {16'h0, arg, 1'b0, op, 2'b0, ch}, q, e, n);
		n = 0;
		if (ov)
			u_host.xfer(1'b1, OFF_CMD, 32'h0f00, q, e, n);
		if (good) begin
			// busy drops SETTLE_CYC + 1 edges after the commit edge
			repeat (SETTLE_CYC - n) @(posedge pclk);
			#1;
			chk("busy mid", 1'b1, busy);
			chk("cfg mid", was, cfg);
			@(posedge pclk);
			#1;
			chk("busy end", 1'b0, busy);
		end else begin
			repeat (2) @(posedge pclk);
			#1;
			chk("busy refused", 1'b0, busy);
		end
		chk("cfg", exp, cfg);
		chk("pll", exp_pll, pll);
		u_host.xfer(1'b0, OFF_STATUS, 32'h0, q, e, n);
		chk("status", {28'h0, ov, ov | ~good, 2'b10}, q);
		u_host.xfer(1'b1, OFF_STATUS, 32'hc, q, e, n);
	endtask : cmd

	initial begin
		#50000;
		bad_count++;
		conclude();
	end

	initial begin
		exp = {NCH{RST_CHAN}};
		exp_pll = '0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		#1;
		chk("reset busy", 1'b1, busy);
		chk("reset cfg", exp, cfg);
		u_host.xfer(1'b0, OFF_STATUS, 32'h0, q, e, n);
		chk("cal status", 32'h1, q);
		u_host.xfer(1'b1, OFF_CMD, 32'h0100, q, e, n);
		u_host.xfer(1'b0, OFF_STATUS, 32'h0, q, e, n);
		chk("cal refuse", 32'hd, q);
		chk("cal cfg", exp, cfg);
		cal_done <= 1'b1;
		u_host.wait_idle(ok);
		chk("cal ready", 1'b1, ok);
		u_host.xfer(1'b1, OFF_STATUS, 32'hc, q, e, n);
		u_host.xfer(1'b0, 8'h0c, 32'h0, q, e, n);
		chk("unmapped", {1'b1, 32'h0}, {e, q});
		cmd(2'd1, OP_CDR, 8'h05, 1'b1, 1'b0);
		cmd(2'd2, OP_PCS, 8'ha5, 1'b1, 1'b1);
		cmd(2'd2, OP_CODER, 8'h00, 1'b1, 1'b0);
		cmd(2'd3, OP_PLLSEL, 8'h01, 1'b1, 1'b0);
		cmd(2'd1, OP_PLLRATE, 8'h87, 1'b1, 1'b0);
		cmd(2'd3, OP_PLLSEL, 8'h03, 1'b0, 1'b0);
		for (int d = 0; d < 4; d++)
			cmd(2'd0, OP_DIV, 8'(3 - d), 1'b1, 1'b0);
		cmd(2'd0, OP_DIV, 8'h04, 1'b0, 1'b0);
		cmd(2'd1, OP_WIDTH, 8'h2b, 1'b1, 1'b0);
		cmd(2'd0, OP_DIR, {6'h0, DIR_TX}, 1'b1, 1'b0);
		cmd(2'd0, OP_DIR, {6'h0, DIR_RX}, 1'b0, 1'b0);
		cmd(2'd1, OP_DIR, {6'h0, DIR_RX}, 1'b1, 1'b0);
		cmd(2'd1, OP_DIR, {6'h0, DIR_TX}, 1'b0, 1'b0);
		cmd(2'd2, OP_DIR, {6'h0, DIR_BAD}, 1'b0, 1'b0);
		cmd(2'd0, OP_DIR, {6'h0, DIR_DUPLEX}, 1'b1, 1'b0);
		cmd(2'd0, OP_PCS, 8'h3c, 1'b1, 1'b0);
		for (int c = 0; c < NCH; c++) begin
			u_host.xfer(1'b0, OFF_CHAN + 8'(4 * c), 32'h0, q, e, n);
			chk("chan reg", {5'h0, exp[c]}, q);
		end
		u_host.xfer(1'b0, OFF_CMD, 32'h0, q, e, n);
		chk("cmd reg", {16'h0, 8'h3c, 1'b0, OP_PCS, 2'b0, 2'd0}, q);
		u_host.xfer(1'b1, OFF_PLL, 32'hfff, q, e, n);
		u_host.xfer(1'b0, OFF_PLL, 32'h0, q, e, n);
		chk("pll reg", {20'h0, exp_pll[1], 4'h0, exp_pll[0]}, q);
		conclude();
	end
endmodule : transceiver_channel_reconfig_bench
`default_nettype wire
